// *** hw/pcc_pkg.sv ***
package pcc_pkg;

  // Byte addresses of the register words
  localparam logic [7:0] A_LOOPS  = 8'h00;
  localparam logic [7:0] A_SCAN   = 8'h04;
  localparam logic [7:0] A_SEL    = 8'h08;
  localparam logic [7:0] A_PRM    = 8'h0C;
  localparam logic [7:0] A_PV     = 8'h38;
  localparam logic [7:0] A_MV     = 8'h3C;
  localparam logic [7:0] A_RUN    = 8'h40;
  localparam logic [7:0] A_OUT    = 8'h44;
  localparam logic [7:0] A_ALARM  = 8'h48;
  localparam logic [7:0] A_STAT   = 8'h4C;
  localparam logic [7:0] A_MASK   = 8'h50;
  localparam logic [7:0] A_LIMITS = 8'h54;
  localparam logic [7:0] A_RATES  = 8'h58;
  localparam logic [7:0] A_FLAGS  = 8'h5C;

  // Per-loop parameter words, index from A_PRM
  localparam int PRM_N = 11;
  localparam logic [3:0] P_SEL = 4'h0;
  localparam logic [3:0] P_TS  = 4'h1;
  localparam logic [3:0] P_KP  = 4'h2;
  localparam logic [3:0] P_TI  = 4'h3;
  localparam logic [3:0] P_TD  = 4'h4;
  localparam logic [3:0] P_FLT = 4'h5;
  localparam logic [3:0] P_OLO = 4'h6;
  localparam logic [3:0] P_OHI = 4'h7;
  localparam logic [3:0] P_ORT = 4'h8;
  localparam logic [3:0] P_PRT = 4'h9;
  localparam logic [3:0] P_KD  = 4'hA;

  // Signed 16-bit range limits
  localparam logic signed [15:0] V_ZERO    = 16'sh0000;
  localparam logic signed [15:0] V_ONE     = 16'sh0001;
  localparam logic signed [15:0] LOOPS_MAX = 16'sh0020;
  localparam logic signed [15:0] TS_MAX    = 16'sh1770;
  localparam logic signed [15:0] KP_MAX    = 16'sh2710;
  localparam logic signed [15:0] TI_MAX    = 16'sh7FFF;
  localparam logic signed [15:0] TD_MAX    = 16'sh7530;
  localparam logic signed [15:0] FLT_MAX   = 16'sh0064;
  localparam logic signed [15:0] OUT_MIN   = 16'shFFCE;
  localparam logic signed [15:0] OUT_MAX   = 16'sh0802;
  localparam logic signed [15:0] RATE_MAX  = 16'sh07D0;
  localparam logic signed [15:0] KD_FINITE = 16'sh7530;

  // Status / mask bits, alarm word bits and flag word bits
  localparam int ST_W      = 5;
  localparam int ST_COMMON = 0;
  localparam int ST_LOOP   = 1;
  localparam int ST_PV     = 2;
  localparam int ST_MV     = 3;
  localparam int ST_DONE   = 4;
  localparam int AL_PV     = 0;
  localparam int AL_MV     = 1;
  localparam int FL_REV    = 0;
  localparam int FL_KDINF  = 1;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       act;
  } pcc_aph_s;

  typedef struct packed {
    logic signed [15:0] hi;
    logic signed [15:0] lo;
  } pcc_pair_s;

endpackage

// *** hw/pcc_param_check.sv ***
`timescale 1ns/1ps
// What this block does
// - Loop count or per-scan count out of 1..32: error, no loop processed.
// - Selector zero means forward action, one means reverse action.
// - Sampling period is a count of 10 ms units, valid 1..6000.
// - Integral time is a count of 100 ms units, valid 1..32767.
// - Derivative time is 10 ms units, valid 0..30000; larger is stronger.
// - Filter coefficient valid 0..100 percent; weaker filtering toward zero.
// - Selector, sampling period, proportional gain, integral, derivative or filter word out of range: error, skip that loop only.
// - Automatic mode: output below lower limit is replaced by the limit.
// - Automatic mode: output above upper limit is replaced by the limit.
// - Output limits are clamped into -50..2050 before use.
// - Output change beyond output rate limit sets alarm bit b1.
// - Excessive output change is not restricted.
// - Output rate limit is clamped into 0..2000 before use.
// - Process change beyond process rate limit sets alarm bit b0.
// - Excessive process change is not restricted.
// - Process rate limit is clamped into 0..2000 before use.
// - Derivative gain above 300.00 is treated as infinite gain.
module pcc_param_check
  import pcc_pkg::*;
#(
  parameter int NL = 32
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             irq
);

  localparam int SW = $clog2(NL);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic in_rng(input logic signed [15:0] v,
                                  input logic signed [15:0] lo,
                                  input logic signed [15:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
                                               input logic signed [15:0] lo,
                                               input logic signed [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Sign-extends a stored word onto the 32-bit read bus
  function automatic logic [31:0] sx(input logic signed [15:0] v);
    sx = {{16{v[15]}}, v};
  endfunction

  // True when |a - b| is above lim; the difference is never altered
  function automatic logic over(input logic signed [15:0] a,
                                input logic signed [15:0] b,
                                input logic signed [15:0] lim);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    if (d < 0) begin
      d = -d;
    end
    over = d > 17'(lim);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  pcc_aph_s           aph_q;
  logic               rdy_q;
  logic [31:0]        rdat_q;
  logic [31:0]        rd_val;
  logic signed [15:0] loops_q;
  logic signed [15:0] scan_q;
  logic [SW-1:0]      sel_q;
  logic signed [15:0] prm_q [PRM_N];
  logic signed [15:0] pv_in_q;
  logic signed [15:0] mv_in_q;
  logic signed [15:0] out_q;
  logic [1:0]         alarm_q;
  logic [1:0]         flags_q;
  logic [ST_W-1:0]    st_q;
  logic [ST_W-1:0]    mask_q;
  logic [ST_W-1:0]    st_set;
  logic               irq_q;
  logic signed [15:0] pmv_q [NL];
  logic signed [15:0] ppv_q [NL];
  logic [NL-1:0]      seen_q;

  wire        acc    = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire        wr_en  = aph_q.act && aph_q.wr;
  wire        rd_ld  = aph_q.act && !aph_q.wr && !rdy_q;
  wire [7:0]  wa     = aph_q.addr;
  wire [15:0] wd     = hwdata[15:0];
  wire [7:0]  prm_o  = wa - A_PRM;
  wire [3:0]  prm_ix = prm_o[5:2];
  wire        prm_hit = (wa >= A_PRM) && (wa < A_PV);
  wire        run_wr = wr_en && (wa == A_RUN);
  wire        auto_m = hwdata[0];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      aph_q <= '0;
    end else if (hready) begin
      aph_q <= '{addr: haddr[7:0], wr: hwrite, act: acc};
    end
  end

  // Reads take one wait state so that a write just before is visible
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_q <= 1'b1;
    end else begin
      rdy_q <= !(acc && !hwrite);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdat_q <= WORD_ZERO;
    end else if (rd_ld) begin
      rdat_q <= rd_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks and conditioning

  wire signed [15:0] mv_prev = pmv_q[sel_q];
  wire signed [15:0] pv_prev = ppv_q[sel_q];

  wire common_ok = in_rng(loops_q, V_ONE, LOOPS_MAX)
                && in_rng(scan_q, V_ONE, LOOPS_MAX);
  wire ok_sel = in_rng(prm_q[P_SEL], V_ZERO, V_ONE);
  wire ok_ts  = in_rng(prm_q[P_TS], V_ONE, TS_MAX);
  wire ok_kp  = in_rng(prm_q[P_KP], V_ONE, KP_MAX);
  wire ok_ti  = in_rng(prm_q[P_TI], V_ONE, TI_MAX);
  wire ok_td  = in_rng(prm_q[P_TD], V_ZERO, TD_MAX);
  wire ok_flt = in_rng(prm_q[P_FLT], V_ZERO, FLT_MAX);
  wire loop_ok = ok_sel && ok_ts && ok_kp && ok_ti && ok_td && ok_flt;

  pcc_pair_s lim;
  assign lim = '{hi: clamp(prm_q[P_OHI], OUT_MIN, OUT_MAX),
                 lo: clamp(prm_q[P_OLO], OUT_MIN, OUT_MAX)};

  pcc_pair_s rate;
  assign rate = '{hi: clamp(prm_q[P_ORT], V_ZERO, RATE_MAX),
                  lo: clamp(prm_q[P_PRT], V_ZERO, RATE_MAX)};

  wire reverse = (prm_q[P_SEL] == V_ONE);
  wire kd_inf  = (prm_q[P_KD] > KD_FINITE);

  // Lower limit is tested first; the raw value passes in manual mode
  wire signed [15:0] out_val = !auto_m         ? mv_in_q :
                               (mv_in_q < lim.lo) ? lim.lo :
                               (mv_in_q > lim.hi) ? lim.hi :
                               mv_in_q;

  // Alarm only; neither change is limited before it is used
  wire mv_ex = seen_q[sel_q] && over(out_val, mv_prev, rate.hi);
  wire pv_ex = seen_q[sel_q] && over(pv_in_q, pv_prev, rate.lo);

  wire eval = run_wr && common_ok && loop_ok;

  always_comb begin
    st_set            = '0;
    st_set[ST_COMMON] = run_wr && !common_ok;
    st_set[ST_LOOP]   = run_wr && common_ok && !loop_ok;
    st_set[ST_PV]     = eval && pv_ex;
    st_set[ST_MV]     = eval && mv_ex;
    st_set[ST_DONE]   = eval;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written words

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      loops_q <= V_ZERO;
      scan_q  <= V_ZERO;
      sel_q   <= '0;
      pv_in_q <= V_ZERO;
      mv_in_q <= V_ZERO;
      mask_q  <= '0;
    end else if (wr_en) begin
      if (wa == A_LOOPS) loops_q <= wd;
      if (wa == A_SCAN)  scan_q  <= wd;
      if (wa == A_SEL)   sel_q   <= hwdata[SW-1:0];
      if (wa == A_PV)    pv_in_q <= wd;
      if (wa == A_MV)    mv_in_q <= wd;
      if (wa == A_MASK)  mask_q  <= hwdata[ST_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < PRM_N; i++) begin
        prm_q[i] <= V_ZERO;
      end
    end else if (wr_en && prm_hit) begin
      prm_q[prm_ix] <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results and per-loop history

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_q   <= V_ZERO;
      alarm_q <= '0;
      flags_q <= '0;
    end else if (eval) begin
      out_q          <= out_val;
      alarm_q[AL_MV] <= mv_ex;
      alarm_q[AL_PV] <= pv_ex;
      flags_q        <= {kd_inf, reverse};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_q <= '0;
      for (int i = 0; i < NL; i++) begin
        pmv_q[i] <= V_ZERO;
        ppv_q[i] <= V_ZERO;
      end
    end else if (eval) begin
      seen_q[sel_q] <= 1'b1;
      pmv_q[sel_q]  <= out_val;
      ppv_q[sel_q]  <= pv_in_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: write one to clear, a new event wins

  wire [ST_W-1:0] st_clr = (wr_en && wa == A_STAT) ? hwdata[ST_W-1:0] : '0;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q  <= '0;
      irq_q <= 1'b0;
    end else begin
      st_q  <= (st_q & ~st_clr) | st_set;
      irq_q <= |(st_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb begin
    rd_val = WORD_ZERO;
    if (prm_hit) begin
      rd_val = sx(prm_q[prm_ix]);
    end else begin
      unique case (wa)
        A_LOOPS:  rd_val = sx(loops_q);
        A_SCAN:   rd_val = sx(scan_q);
        A_SEL:    rd_val = 32'(sel_q);
        A_PV:     rd_val = sx(pv_in_q);
        A_MV:     rd_val = sx(mv_in_q);
        A_OUT:    rd_val = sx(out_q);
        A_ALARM:  rd_val = 32'(alarm_q);
        A_STAT:   rd_val = 32'(st_q);
        A_MASK:   rd_val = 32'(mask_q);
        A_LIMITS: rd_val = lim;
        A_RATES:  rd_val = rate;
        A_FLAGS:  rd_val = 32'(flags_q);
        default:  rd_val = WORD_ZERO;
      endcase
    end
  end

  assign hrdata    = rdat_q;
  assign hreadyout = rdy_q;
  assign hresp     = 1'b0;
  assign irq       = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  property p_rd_wait;
    acc && !hwrite |=> s_rd_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");

  property p_common_skip;
    run_wr && !common_ok |=> st_q[ST_COMMON] && $stable(out_q) && $stable(seen_q);
  endproperty
  a_common_skip: assert property (p_common_skip) else $error("common error missed");

  property p_loop_skip;
    run_wr && common_ok && !loop_ok |=> st_q[ST_LOOP] && $stable(out_q);
  endproperty
  a_loop_skip: assert property (p_loop_skip) else $error("loop error missed");

  property p_low_clamp;
    eval && auto_m && (mv_in_q < lim.lo) |=> out_q == $past(lim.lo);
  endproperty
  a_low_clamp: assert property (p_low_clamp) else $error("low limit not applied");

  property p_high_clamp;
    eval && auto_m && (mv_in_q > lim.hi) && (mv_in_q >= lim.lo)
      |=> out_q == $past(lim.hi);
  endproperty
  a_high_clamp: assert property (p_high_clamp) else $error("high limit not applied");

  property p_out_span;
    eval && auto_m |=> (out_q >= OUT_MIN) && (out_q <= OUT_MAX);
  endproperty
  a_out_span: assert property (p_out_span) else $error("output beyond span");

  property p_mv_alarm;
    eval && mv_ex |=> alarm_q[AL_MV] && st_q[ST_MV];
  endproperty
  a_mv_alarm: assert property (p_mv_alarm) else $error("output rate alarm missed");

  property p_manual_pass;
    eval && !auto_m |=> out_q == $past(mv_in_q);
  endproperty
  a_manual_pass: assert property (p_manual_pass) else $error("output altered");

  property p_rate_span;
    (rate.hi >= V_ZERO) && (rate.hi <= RATE_MAX)
      && (rate.lo >= V_ZERO) && (rate.lo <= RATE_MAX);
  endproperty
  a_rate_span: assert property (p_rate_span) else $error("rate limit beyond span");

  property p_pv_alarm;
    eval && pv_ex |=> alarm_q[AL_PV] && st_q[ST_PV];
  endproperty
  a_pv_alarm: assert property (p_pv_alarm) else $error("process rate alarm missed");

  // A loop's first good evaluation has no history to compare against
  sequence s_fresh_loop;
    eval && !seen_q[sel_q];
  endsequence

  property p_first_quiet;
    s_fresh_loop |=> (alarm_q == '0) && seen_q[$past(sel_q)];
  endproperty
  a_first_quiet: assert property (p_first_quiet) else $error("first evaluation alarmed");

  property p_flags;
    eval |=> (flags_q[FL_KDINF] == ($past(prm_q[P_KD]) > KD_FINITE))
             && (flags_q[FL_REV] == ($past(prm_q[P_SEL]) == V_ONE));
  endproperty
  a_flags: assert property (p_flags) else $error("action or gain flag wrong");

  property p_done;
    eval |=> st_q[ST_DONE];
  endproperty
  a_done: assert property (p_done) else $error("done status missed");

  property p_irq;
    (|(st_q & mask_q)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule

// *** test/pcc_host.sv ***
`timescale 1ns/1ps
module pcc_host
  import pcc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  output logic             hang
);
  initial begin
    hsel   = 1'b0;
    haddr  = WORD_ZERO;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = WORD_ZERO;
    hang   = 1'b0;
  end

  // Bounded wait for hready high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1 && n < 64) begin
      n++;
      @(posedge ref_clk);
    end
    if (hreadyout !== 1'b1) begin
      hang <= 1'b1;
    end
  endtask

  // One single-word transfer; read data taken at the edge ending the data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench
  import pcc_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic        hang;
  int          num_errors = 0;
  int          check_count = 0;

  localparam logic [15:0] DFLT [PRM_N] = '{16'h0000, 16'h0064, 16'h0064, 16'h000A,
    16'h0000, 16'h0000, 16'hFFCE, 16'h0802, 16'h0064, 16'h0064, 16'h0000};
  localparam int          BI [10] = '{0, 1, 1, 2, 2, 3, 4, 4, 5, 5};
  localparam logic [15:0] BB [10] = '{16'h0002, 16'h0000, 16'h1771, 16'h0000, 16'h2711,
    16'h0000, 16'hFFFF, 16'h7531, 16'hFFFF, 16'h0065};
  localparam logic [15:0] BG [10] = '{16'h0001, 16'h1770, 16'h0001, 16'h2710, 16'h0001,
    16'h7FFF, 16'h7530, 16'h0000, 16'h0064, 16'h0000};

  always #25 ref_clk = ~ref_clk;

  pcc_param_check #(.NL(32)) uut (
    .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

  pcc_host host (
    .ref_clk(ref_clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hang(hang));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge hang) begin
    num_errors++;
    conclude();
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    host.xfer(1'b0, a, WORD_ZERO, q);
    check(name, q, exp);
  endtask

  task automatic w16(input logic [7:0] a, input logic [15:0] v);
    wr(a, {{16{v[15]}}, v});
  endtask

  task automatic prm(input int i, input logic [15:0] v);
    w16(A_PRM + 8'(4 * i), v);
  endtask

  task automatic run(input logic am);
    wr(A_RUN, {31'h0000_0000, am});
  endtask

  task automatic load(input logic [15:0] sel);
    w16(A_SEL, sel);
    for (int i = 0; i < PRM_N; i++) begin
      prm(i, DFLT[i]);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_common();
    logic [15:0] bad [3];
    bad = '{16'h0000, 16'h0021, 16'hFFFF};
    rd_chk("status reset", A_STAT, WORD_ZERO);
    check("hresp", {31'h0000_0000, hresp}, WORD_ZERO);
    wr(8'h80, 32'h1234_5678);
    rd_chk("unmapped", 8'h80, WORD_ZERO);
    load(16'h0000);
    w16(A_SCAN, 16'h0001);
    foreach (bad[i]) begin
      w16(A_LOOPS, bad[i]);
      run(1'b1);
      rd_chk("loop count err", A_STAT, 32'h0000_0001);
      wr(A_STAT, 32'h0000_001F);
    end
    w16(A_LOOPS, LOOPS_MAX);
    w16(A_SCAN, 16'h0021);
    run(1'b1);
    rd_chk("scan count err", A_STAT, 32'h0000_0001);
    w16(A_SCAN, LOOPS_MAX);
    wr(A_STAT, 32'h0000_001F);
    run(1'b1);
    rd_chk("common ok", A_STAT, 32'h0000_0010);
    wr(A_STAT, 32'h0000_001F);
    $display("test common done");
  endtask

  task automatic t_loop();
    foreach (BI[i]) begin
      load(16'h0000);
      prm(BI[i], BB[i]);
      run(1'b1);
      rd_chk("loop err", A_STAT, 32'h0000_0002);
      wr(A_STAT, 32'h0000_001F);
      prm(BI[i], BG[i]);
      run(1'b1);
      rd_chk("loop ok", A_STAT, 32'h0000_0010);
      wr(A_STAT, 32'h0000_001F);
    end
    prm(0, 16'h0001);
    prm(10, KD_FINITE + 16'sh0001);
    run(1'b1);
    rd_chk("flags", A_FLAGS, 32'h0000_0003);
    prm(0, 16'h0000);
    prm(10, KD_FINITE);
    run(1'b1);
    rd_chk("flags", A_FLAGS, 32'h0000_0000);
    $display("test loop done");
  endtask

  task automatic t_clamp();
    load(16'h0000);
    prm(6, 16'hFF9C);
    prm(7, 16'h0BB8);
    prm(8, 16'hFFFB);
    prm(9, 16'h1388);
    w16(A_MV, 16'hFFC4);
    run(1'b1);
    rd_chk("limits", A_LIMITS, 32'h0802_FFCE);
    rd_chk("rates", A_RATES, 32'h0000_07D0);
    rd_chk("out low", A_OUT, 32'hFFFF_FFCE);
    w16(A_MV, 16'h0834);
    run(1'b1);
    rd_chk("out high", A_OUT, 32'h0000_0802);
    run(1'b0);
    rd_chk("out manual", A_OUT, 32'h0000_0834);
    wr(A_STAT, 32'h0000_001F);
    $display("test clamp done");
  endtask

  task automatic t_alarm();
    load(16'h0001);
    w16(A_PV, 16'h0000);
    w16(A_MV, 16'h0000);
    run(1'b1);
    rd_chk("alarm first", A_ALARM, WORD_ZERO);
    w16(A_PV, 16'h0065);
    w16(A_MV, 16'h0064);
    run(1'b1);
    rd_chk("alarm pv", A_ALARM, 32'h0000_0001);
    rd_chk("out free", A_OUT, 32'h0000_0064);
    w16(A_MV, 16'h00C9);
    run(1'b1);
    rd_chk("alarm mv", A_ALARM, 32'h0000_0002);
    rd_chk("out free", A_OUT, 32'h0000_00C9);
    wr(A_STAT, 32'h0000_001F);
    w16(A_PV, 16'h0000);
    w16(A_MV, 16'h0064);
    run(1'b1);
    rd_chk("alarm both", A_ALARM, 32'h0000_0003);
    rd_chk("status", A_STAT, 32'h0000_001C);
    check("irq masked", {31'h0000_0000, irq}, WORD_ZERO);
    wr(A_MASK, 32'h0000_0008);
    rd_chk("mask", A_MASK, 32'h0000_0008);
    check("irq on", {31'h0000_0000, irq}, 32'h0000_0001);
    wr(A_STAT, 32'h0000_0008);
    rd_chk("status w1c", A_STAT, 32'h0000_0014);
    check("irq off", {31'h0000_0000, irq}, WORD_ZERO);
    wr(A_MASK, 32'h0000_0004);
    rd_chk("mask", A_MASK, 32'h0000_0004);
    check("irq pv", {31'h0000_0000, irq}, 32'h0000_0001);
    wr(A_STAT, 32'h0000_001F);
    wr(A_MASK, WORD_ZERO);
    $display("test alarm done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_common();
    t_loop();
    t_clamp();
    t_alarm();
    conclude();
  end
endmodule
